/* hw/charger_adc_sequencer_irq.sv */
`timescale 1ns/1ps
`default_nettype none
`include "charger_params.svh"

// Notes on behaviour
// - no valid battery or bus supply: skip conversion, clear enable, no interrupt
// - oneshot 1 runs one cycle then clears enable; 0 runs continuously
// - single-pass enable with every channel disabled behaves like the invalid-supply case
// - continuous keeps enable set with all channels off, converter idle; single-pass clears enable
// - mode change pauses conversion; resumes at the interrupted channel
// - two-bit sample speed selects the per-measurement conversion time
// - channel-disable register resets to zero, all channels converted
// - disabled channel keeps its old result or the reset default
// - disable set mid-cycle: channel still converted this cycle, skipped next
// - clearing a disable bit while enabled starts conversion promptly
// - done status and latch set only by completed single-pass cycle
// - clearing enable stops at once; results keep last valid values
// - all channels disabled stops converter after current cycle completes
// - adapter plug-in suspends until detection ends; faults do not stop it
// - source good only with bus in window, not poor, detection complete
// - a reportable event with no pulse under way drives interrupt pin low for 256 us
// - listed charger events pulse the interrupt by default
// - rising edge of any status bit at 0x0b..0x0e pulses the interrupt
// - mask bit 1 suppresses that event's interrupt pulse
// - every event except loss of source good recorded in its latch regardless of present status
// - reading latch clears it; only fresh rising edge or code change sets it again
// - limit-active status bits follow input current and voltage limiting
module charger_adc_sequencer_irq
    import charger_pkg::*;
#(
    parameter int unsigned INT_PULSE_CYCLES = `INT_PULSE_US * `CLK_MHZ
) (
    input wire logic sys_clk, // 100 MHz clock
    input wire logic nrst, // synchronous reset, active low
    input wire logic [7:0] reg_addr, // register offset from serial front end
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // one-cycle write strobe
    input wire logic reg_rd, // one-cycle read strobe
    output logic [7:0] reg_rdata, // read data, one cycle after strobe
    input wire logic vbat_valid, // battery above its lockout
    input wire logic vbus_valid, // bus within its lockout window
    input wire logic vbus_window_ok, // bus in operating range
    input wire logic source_not_poor, // poor-source test passed
    input wire logic type_detect_done, // source type detection complete
    input wire logic source_detect_busy, // plug-in detection running
    input wire logic mode_change_busy, // reverse output or high impedance change
    input wire logic thermal_reg_in, // junction temperature regulation
    input wire logic input_voltage_limiting, // input voltage limit loop active
    input wire logic input_current_limiting, // input current limit loop active
    input wire logic watchdog_expired, // watchdog timeout
    input wire logic batt_ovp, // battery overvoltage
    input wire logic thermal_shutdown, // thermal shutdown
    input wire logic vbus_ovp, // bus overvoltage
    input wire logic safety_timer_expired, // safety or precharge timer expired
    input wire logic [2:0] source_type_code, // source type
    input wire logic [2:0] thermistor_zone_code, // thermistor zone
    input wire logic [2:0] charge_phase_code, // charge phase
    input wire logic [15:0] conv_data, // converter result, held by analog
    output logic conv_active, // converter running a measurement
    output logic [2:0] conv_channel, // channel being measured
    output logic [1:0] conv_speed, // sample speed to analog
    output logic power_good_pin_n, // power good, active low
    output logic interrupt_pulse_pin_n // interrupt pulse, active low
);

    localparam logic [15:0] INT_LEN = 16'(INT_PULSE_CYCLES);

    // ascending search for the next enabled channel at or after from
    function automatic logic [2:0] next_ch(input logic [6:0] en, input logic [2:0] from);
        logic [2:0] res;
        logic found;
        res = `CH_NONE;
        found = 1'b0;
        for (int i = 0; i < `NUM_CH; i++) begin
            if (!found && en[i] && (3'(i) >= from)) begin
                res = 3'(i);
                found = 1'b1;
            end
        end
        return res;
    endfunction

    // two-stage synchroniser for every analog-side input
    logic [39:0] sync1_r;
    logic [39:0] sync2_r;
    wire [39:0] raw_in = {conv_data, charge_phase_code, thermistor_zone_code,
        source_type_code, safety_timer_expired, vbus_ovp, thermal_shutdown,
        batt_ovp, watchdog_expired, input_current_limiting,
        input_voltage_limiting, thermal_reg_in, mode_change_busy,
        source_detect_busy, type_detect_done, source_not_poor,
        vbus_window_ok, vbus_valid, vbat_valid};

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            sync1_r <= '0;
            sync2_r <= '0;
        end else begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
        end
    end

    wire [15:0] d_data;
    wire [2:0] d_phase, d_zone, d_type;
    wire d_timer, d_vbusovp, d_tshut, d_batovp, d_wdt, d_iin, d_vin, d_treg, d_mode;
    wire d_detbusy, d_detdone, d_notpoor, d_window, d_vbus, d_vbat;
    assign {d_data, d_phase, d_zone, d_type, d_timer, d_vbusovp, d_tshut,
        d_batovp, d_wdt, d_iin, d_vin, d_treg, d_mode, d_detbusy,
        d_detdone, d_notpoor, d_window, d_vbus, d_vbat} = sync2_r;

    // register state
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [7:0] chdis_r;
    logic [15:0] mask_r;
    logic [15:0] flag_r;
    logic [15:0] flag_nxt;
    logic [15:0] ev_prev_r;
    logic [8:0] code_prev_r;
    logic adc_done_r;
    logic adc_done_nxt;
    logic src_good_r;
    logic [7:0] rdata_r;
    conv_word_t res_r [0:`NUM_CH-1];

    // sequencer state
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic [2:0] chan_r;
    logic [2:0] chan_nxt;
    logic [6:0] cyc_en_r;
    logic [6:0] cyc_en_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic clr_en;
    logic done_set;
    logic store;

    // interrupt pulse
    logic [15:0] int_cnt_r;
    logic [15:0] int_cnt_nxt;

    wire wr_ctrl = reg_wr && (reg_addr == `ADDR_CTRL);
    wire wr_chdis = reg_wr && (reg_addr == `ADDR_CHDIS);
    wire wr_mask0 = reg_wr && (reg_addr == `ADDR_MASK0);
    wire wr_mask1 = reg_wr && (reg_addr == `ADDR_MASK1);
    wire rd_flag0 = reg_rd && (reg_addr == `ADDR_FLAG0);
    wire rd_flag1 = reg_rd && (reg_addr == `ADDR_FLAG1);

    wire conv_en = ctrl_r[`CTRL_EN];
    wire oneshot = ctrl_r[`CTRL_ONESHOT];
    wire [1:0] speed = ctrl_r[`CTRL_SPD_HI:`CTRL_SPD_LO];
    wire [6:0] ch_on = ~chdis_r[6:0];
    wire all_off = (ch_on == 7'h00);
    wire supply_ok = d_vbat | d_vbus;
    // faults are deliberately absent here: only mode changes and plug-in detection pause the sequencer
    wire suspend = d_mode | d_detbusy;
    wire [2:0] first_ch = next_ch(ch_on, 3'h0);
    wire [2:0] after_ch = next_ch(cyc_en_r, chan_r + 3'h1);

    wire [15:0] conv_len = (speed == 2'h0) ? 16'(`CONV_CYC_0) :
        (speed == 2'h1) ? 16'(`CONV_CYC_1) :
        (speed == 2'h2) ? 16'(`CONV_CYC_2) : 16'(`CONV_CYC_3);
    wire conv_last = (cnt_r == conv_len - 16'h0001);

    always_comb begin
        state_nxt = state_r;
        chan_nxt = chan_r;
        cyc_en_nxt = cyc_en_r;
        cnt_nxt = cnt_r;
        clr_en = 1'b0;
        done_set = 1'b0;
        store = 1'b0;
        case (state_r)
            SEQ_IDLE: begin
                if (conv_en) begin
                    if (!supply_ok) begin
                        clr_en = 1'b1;
                    end else if (all_off) begin
                        // continuous mode idles here until a channel returns
                        clr_en = oneshot;
                    end else begin
                        // snapshot so mid-cycle disables take effect next cycle
                        cyc_en_nxt = ch_on;
                        chan_nxt = first_ch;
                        cnt_nxt = 16'h0000;
                        state_nxt = SEQ_CONV;
                    end
                end
            end
            SEQ_CONV: begin
                if (!conv_en) begin
                    state_nxt = SEQ_IDLE;
                end else if (suspend) begin
                    state_nxt = SEQ_SUSP;
                end else if (conv_last) begin
                    store = 1'b1;
                    cnt_nxt = 16'h0000;
                    if (after_ch == `CH_NONE) begin
                        state_nxt = SEQ_IDLE;
                        clr_en = oneshot;
                        done_set = oneshot;
                    end else begin
                        chan_nxt = after_ch;
                    end
                end else begin
                    cnt_nxt = cnt_r + 16'h0001;
                end
            end
            SEQ_SUSP: begin
                if (!conv_en) begin
                    state_nxt = SEQ_IDLE;
                end else if (!suspend) begin
                    // the partial measurement is lost; the same channel restarts
                    cnt_nxt = 16'h0000;
                    state_nxt = SEQ_CONV;
                end
            end
            default: begin
                state_nxt = SEQ_IDLE;
            end
        endcase
    end

    // a host write beats a same-cycle automatic clear of the enable
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_ctrl) begin
            ctrl_nxt = reg_wdata;
        end else if (clr_en) begin
            ctrl_nxt[`CTRL_EN] = 1'b0;
        end
    end

    // done status is a single-pass artefact; rearming the enable clears it
    assign adc_done_nxt = done_set ? 1'b1 :
        (!oneshot || (wr_ctrl && reg_wdata[`CTRL_EN])) ? 1'b0 : adc_done_r;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            state_r <= SEQ_IDLE;
            chan_r <= 3'h0;
            cyc_en_r <= 7'h00;
            cnt_r <= 16'h0000;
            ctrl_r <= `RST_CTRL;
            chdis_r <= `RST_CHDIS;
            mask_r <= `RST_MASK;
            adc_done_r <= 1'b0;
            conv_active <= 1'b0;
            conv_channel <= 3'h0;
            conv_speed <= 2'h0;
        end else begin
            state_r <= state_nxt;
            chan_r <= chan_nxt;
            cyc_en_r <= cyc_en_nxt;
            cnt_r <= cnt_nxt;
            ctrl_r <= ctrl_nxt;
            adc_done_r <= adc_done_nxt;
            if (wr_chdis) begin
                chdis_r <= reg_wdata;
            end
            if (wr_mask0) begin
                mask_r[15:8] <= reg_wdata;
            end
            if (wr_mask1) begin
                mask_r[7:0] <= reg_wdata;
            end
            conv_active <= (state_nxt == SEQ_CONV);
            conv_channel <= chan_nxt;
            conv_speed <= ctrl_nxt[`CTRL_SPD_HI:`CTRL_SPD_LO];
        end
    end

    // results: only a completed channel overwrites its word
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            for (int i = 0; i < `NUM_CH; i++) begin
                res_r[i] <= `RST_RESULT;
            end
        end else if (store) begin
            res_r[chan_r] <= d_data;
        end
    end

    // status and events
    wire pg_now = d_window & d_notpoor & d_detdone;
    wire [7:0] stat0 = {src_good_r, d_vbusovp, d_treg, d_vin, d_iin, d_wdt,
        d_batovp, d_tshut};
    wire [7:0] stat1 = {adc_done_r, d_timer, 6'h00};
    wire [7:0] code0 = {d_type, d_phase, 2'h0};
    wire [7:0] code1 = {d_zone, 5'h00};
    wire [15:0] ev_live = {stat0, stat1};
    wire [8:0] code_now = {d_type, d_zone, d_phase};
    wire chg_type = (code_now[8:6] != code_prev_r[8:6]);
    wire chg_zone = (code_now[5:3] != code_prev_r[5:3]);
    wire chg_phase = (code_now[2:0] != code_prev_r[2:0]);
    wire [15:0] ev_rise = ev_live & ~ev_prev_r;
    wire [15:0] ev_hit = ev_rise | {10'h000, chg_type, chg_zone, chg_phase, 3'h0};
    // removal of a good source interrupts but does not latch
    wire [15:0] ev_fall = {ev_prev_r[15] & ~ev_live[15], 15'h0000};
    wire int_any = |((ev_hit | ev_fall) & ~mask_r);
    wire int_busy = (int_cnt_r != 16'h0000);

    // a set in the cycle of the clearing read survives it
    assign flag_nxt = (flag_r & ~{{8{rd_flag0}}, {8{rd_flag1}}}) | ev_hit;

    // a pulse under way runs out untouched; later events wait in the latches
    assign int_cnt_nxt = int_busy ? (int_cnt_r - 16'h0001) :
        (int_any ? INT_LEN : 16'h0000);

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            ev_prev_r <= 16'h0000;
            code_prev_r <= 9'h000;
            flag_r <= 16'h0000;
            src_good_r <= 1'b0;
            int_cnt_r <= 16'h0000;
            power_good_pin_n <= 1'b1;
            interrupt_pulse_pin_n <= 1'b1;
        end else begin
            ev_prev_r <= ev_live;
            code_prev_r <= code_now;
            flag_r <= flag_nxt;
            src_good_r <= pg_now;
            power_good_pin_n <= ~pg_now;
            int_cnt_r <= int_cnt_nxt;
            interrupt_pulse_pin_n <= (int_cnt_nxt == 16'h0000);
        end
    end

    // read path
    wire in_res = (reg_addr >= `ADDR_RES_BASE) && (reg_addr <= `ADDR_RES_LAST);
    wire [7:0] res_off = reg_addr - `ADDR_RES_BASE;
    wire [15:0] res_word = res_r[res_off[3:1]];
    wire [7:0] res_byte = res_off[0] ? res_word[15:8] : res_word[7:0];
    wire [7:0] rd_val;
    assign rd_val = (reg_addr == `ADDR_STAT0) ? stat0 :
        (reg_addr == `ADDR_STAT1) ? stat1 :
        (reg_addr == `ADDR_CODE0) ? code0 :
        (reg_addr == `ADDR_CODE1) ? code1 :
        (reg_addr == `ADDR_FLAG0) ? flag_r[15:8] :
        (reg_addr == `ADDR_FLAG1) ? flag_r[7:0] :
        (reg_addr == `ADDR_MASK0) ? mask_r[15:8] :
        (reg_addr == `ADDR_MASK1) ? mask_r[7:0] :
        (reg_addr == `ADDR_CTRL) ? ctrl_r :
        (reg_addr == `ADDR_CHDIS) ? chdis_r :
        in_res ? res_byte :
        (reg_addr > `ADDR_LAST) ? `RD_UNMAPPED : `RD_RESERVED;

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            rdata_r <= `RD_RESERVED;
        end else if (reg_rd) begin
            rdata_r <= rd_val;
        end
    end

    assign reg_rdata = rdata_r;

endmodule // charger_adc_sequencer_irq

`default_nettype wire

/* hw/charger_params.svh */
`ifndef CHARGER_PARAMS_SVH
`define CHARGER_PARAMS_SVH

// clock and timing
`define CLK_MHZ 100
`define INT_PULSE_US 256
`define CONV_US_0 24
`define CONV_US_1 12
`define CONV_US_2 6
`define CONV_US_3 3
`define CONV_CYC_0 (`CONV_US_0 * `CLK_MHZ)
`define CONV_CYC_1 (`CONV_US_1 * `CLK_MHZ)
`define CONV_CYC_2 (`CONV_US_2 * `CLK_MHZ)
`define CONV_CYC_3 (`CONV_US_3 * `CLK_MHZ)

// register offsets
`define ADDR_STAT0 8'h0b
`define ADDR_STAT1 8'h0c
`define ADDR_CODE0 8'h0d
`define ADDR_CODE1 8'h0e
`define ADDR_FLAG0 8'h0f
`define ADDR_FLAG1 8'h10
`define ADDR_MASK0 8'h11
`define ADDR_MASK1 8'h12
`define ADDR_CTRL 8'h15
`define ADDR_CHDIS 8'h16
`define ADDR_RES_BASE 8'h17
`define ADDR_RES_LAST 8'h24
`define ADDR_LAST 8'h25

// control register fields
`define CTRL_EN 7
`define CTRL_ONESHOT 6
`define CTRL_SPD_HI 5
`define CTRL_SPD_LO 4

// reset values and read answers
`define RST_CTRL 8'h00
`define RST_CHDIS 8'h00
`define RST_MASK 16'h0000
`define RST_RESULT 16'h0000
`define RD_UNMAPPED 8'hff
`define RD_RESERVED 8'h00

// channels
`define NUM_CH 7
`define CH_NONE 3'h7

`endif

/* hw/charger_pkg.sv */
package charger_pkg;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONV,
        SEQ_SUSP
    } seq_state_t;

    typedef logic [15:0] conv_word_t;

endpackage

/* tb/analog_front_model.sv */
`timescale 1ns/1ps
`default_nettype none
module analog_front_model (
    input wire logic sys_clk, // clock
    input wire logic conv_active, // measuring
    input wire logic [2:0] conv_channel, // channel under measurement
    output logic [15:0] conv_data // sampled value
);
    initial conv_data = 16'h0000;
    // outside a measurement the value toggles every cycle so a stale capture shows up
    always @(posedge sys_clk) begin
        if (conv_active) begin
            conv_data <= {5'h15, conv_channel, 5'h0a, conv_channel};
        end else begin
            conv_data <= ~conv_data;
        end
    end
endmodule // analog_front_model
`default_nettype wire

/* tb/charger_props.sv */
`timescale 1ns/1ps
`default_nettype none
module charger_props #(
    parameter int unsigned INT_PULSE_CYCLES = 25600
) (
    input wire logic sys_clk, // clock
    input wire logic nrst, // reset, active low
    input wire logic [7:0] reg_addr, // offset
    input wire logic [7:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [7:0] reg_rdata, // read data
    input wire logic vbus_window_ok, // bus in range
    input wire logic source_not_poor, // not poor
    input wire logic type_detect_done, // detection done
    input wire logic conv_active, // measuring
    input wire logic [2:0] conv_channel, // channel
    input wire logic [1:0] conv_speed, // speed
    input wire logic power_good_pin_n, // power good
    input wire logic interrupt_pulse_pin_n // interrupt
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    logic [31:0] low_cnt_r;
    logic [15:0] dwell_r;
    logic [2:0] pg_on_r, pg_off_r, ch_q_r;
    logic act_q_r;
    wire logic good_in = vbus_window_ok & source_not_poor & type_detect_done;
    wire logic wr_ctrl = reg_wr && reg_addr == 8'h15;
    wire logic [1:0] wspd = reg_wdata[5:4];
    wire logic [15:0] conv_len = 16'h0960 >> conv_speed;
    wire logic ch_step = conv_active && act_q_r && conv_channel != ch_q_r;
    // pg_on_r and pg_off_r saturate so a long steady input never wraps back below the threshold
    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            low_cnt_r <= 32'h0;
            dwell_r <= 16'h0;
            pg_on_r <= 3'h0;
            pg_off_r <= 3'h0;
            ch_q_r <= 3'h0;
            act_q_r <= 1'b0;
        end else begin
            low_cnt_r <= interrupt_pulse_pin_n ? 32'h0 : low_cnt_r + 32'h1;
            dwell_r <= (conv_active && act_q_r && !ch_step) ? dwell_r + 16'h1 : 16'h1;
            pg_on_r <= good_in ? pg_on_r + {2'h0, pg_on_r != 3'h7} : 3'h0;
            pg_off_r <= !good_in ? pg_off_r + {2'h0, pg_off_r != 3'h7} : 3'h0;
            ch_q_r <= conv_channel;
            act_q_r <= conv_active;
        end
    end
    AST_PG_ON: assert property (pg_on_r >= 3'h4 |-> !power_good_pin_n)
        else $error("power good missing with good source");
    AST_PG_OFF: assert property (pg_off_r >= 3'h4 |-> power_good_pin_n)
        else $error("power good shown without good source");
    AST_INT_WIDTH: assert property ($rose(interrupt_pulse_pin_n) |-> low_cnt_r == INT_PULSE_CYCLES)
        else $error("interrupt pulse width wrong");
    AST_INT_MAX: assert property (low_cnt_r <= INT_PULSE_CYCLES)
        else $error("interrupt pulse lengthened");
    AST_SPEED: assert property (wr_ctrl ##1 !wr_ctrl |=> conv_speed == $past(wspd, 2))
        else $error("sample speed not taken from control write");
    AST_STOP: assert property (wr_ctrl && !reg_wdata[7] |-> ##2 !conv_active [*2])
        else $error("converter still running after disable");
    AST_ORDER: assert property (ch_step |-> conv_channel > ch_q_r)
        else $error("channel order not ascending");
    AST_DWELL: assert property (ch_step |-> dwell_r == conv_len)
        else $error("channel conversion time wrong");
    AST_RDATA_HOLD: assert property (!reg_rd && !$past(reg_rd) |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    cover property (!interrupt_pulse_pin_n);
    cover property (conv_active && conv_channel == 3'h6);
    cover property (!power_good_pin_n);
endmodule // charger_props

bind charger_adc_sequencer_irq charger_props #(.INT_PULSE_CYCLES(INT_PULSE_CYCLES)) charger_props_inst (
    .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .vbus_window_ok,
    .source_not_poor, .type_detect_done, .conv_active, .conv_channel, .conv_speed,
    .power_good_pin_n, .interrupt_pulse_pin_n
);
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int PULSE = 16;
    logic sys_clk, nrst, reg_wr, reg_rd, vbat_valid, vbus_valid;
    logic [7:0] reg_addr, reg_wdata;
    logic [11:0] ev;
    logic [1:0] busy;
    wire logic [7:0] reg_rdata;
    wire logic [15:0] conv_data;
    wire logic conv_active, power_good_pin_n, interrupt_pulse_pin_n;
    wire logic [2:0] conv_channel;
    wire logic [1:0] conv_speed;
    int err_count = 0, cmp_count = 0, cyc = 0, falls = 0;

    charger_adc_sequencer_irq #(.INT_PULSE_CYCLES(PULSE)) charger_adc_sequencer_irq_inst (
        .sys_clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .vbat_valid,
        .vbus_valid, .vbus_window_ok(ev[11]), .source_not_poor(ev[11]),
        .type_detect_done(ev[11]), .source_detect_busy(busy[1]), .mode_change_busy(busy[0]),
        .thermal_reg_in(ev[5]), .input_voltage_limiting(ev[4]), .input_current_limiting(ev[3]),
        .watchdog_expired(ev[2]), .batt_ovp(ev[1]), .thermal_shutdown(ev[0]), .vbus_ovp(ev[6]),
        .safety_timer_expired(ev[7]), .source_type_code({2'h0, ev[8]}),
        .thermistor_zone_code({2'h0, ev[9]}), .charge_phase_code({2'h0, ev[10]}), .conv_data,
        .conv_active, .conv_channel, .conv_speed, .power_good_pin_n, .interrupt_pulse_pin_n
    );
    analog_front_model analog_front_model_inst (.sys_clk, .conv_active, .conv_channel,
        .conv_data);

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end
    always @(negedge interrupt_pulse_pin_n) falls++;
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_count++;
            print_verdict();
        end
    end

    task automatic print_verdict();
        $display("errors %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // the extra edge keeps a following write from reassigning the strobe in the same step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string name);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(posedge sys_clk);
        @(negedge sys_clk);
        check(name, {8'h0, reg_rdata}, {8'h0, exp});
        @(posedge sys_clk);
    endtask
    task automatic pulse();
        int w;
        w = 0;
        for (int i = 0; i < 3000 && interrupt_pulse_pin_n !== 1'b0; i++) @(negedge sys_clk);
        while (interrupt_pulse_pin_n === 1'b0 && w < 100) begin
            @(negedge sys_clk);
            w++;
        end
        check("int width", 16'(w), 16'(PULSE));
        @(posedge sys_clk);
    endtask
    function automatic logic [7:0] flag_a(input int k);
        return (k >= 7 && k <= 10) ? 8'h10 : 8'h0f;
    endfunction
    function automatic logic [7:0] flag_v(input int k);
        return k < 7 ? 8'h01 << k : k == 7 ? 8'h40 : k == 11 ? 8'h80 : 8'h20 >> (k - 8);
    endfunction

    initial begin
        int f0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        vbat_valid = 1'b1;
        vbus_valid = 1'b1;
        ev = 12'h000;
        busy = 2'h0;
        nrst = 1'b0;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdc(8'h16, 8'h00, "chdis reset");
        rdc(8'h17, 8'h00, "result reset");
        // each event: pulse, latch, clear on read, and what its falling edge does
        for (int k = 0; k < 12; k++) begin
            ev[k] <= 1'b1;
            pulse();
            rdc(flag_a(k), flag_v(k), "flag set");
            rdc(flag_a(k), 8'h00, "flag cleared");
            if (k < 8 || k == 11) rdc(flag_a(k) - 8'h04, flag_v(k), "status live");
            if (k == 11) check("pg pin", {15'h0, power_good_pin_n}, 16'h0);
            f0 = falls;
            ev[k] <= 1'b0;
            repeat (PULSE + 20) @(posedge sys_clk);
            check("fall pulses", 16'(falls - f0), (k >= 8) ? 16'h1 : 16'h0);
            rdc(flag_a(k), (k >= 8 && k <= 10) ? flag_v(k) : 8'h00, "flag after fall");
        end
        wr(8'h11, 8'h04);
        f0 = falls;
        ev[2] <= 1'b1;
        repeat (PULSE + 10) @(posedge sys_clk);
        check("masked pulses", 16'(falls - f0), 16'h0);
        rdc(8'h0f, 8'h04, "masked flag");
        ev[2] <= 1'b0;
        wr(8'h11, 8'h00);
        f0 = falls;
        ev[0] <= 1'b1;
        repeat (6) @(posedge sys_clk);
        ev[1] <= 1'b1;
        repeat (PULSE * 2 + 10) @(posedge sys_clk);
        check("pulses in burst", 16'(falls - f0), 16'h1);
        rdc(8'h0f, 8'h03, "burst flags");
        ev[1:0] <= 2'b00;
        // single pass at the fastest speed with channel 2 disabled beforehand
        wr(8'h16, 8'h04);
        wr(8'h15, 8'hf0);
        rdc(8'h15, 8'hf0, "enable readback");
        pulse();
        rdc(8'h15, 8'h70, "oneshot enable");
        rdc(8'h0c, 8'h80, "done status");
        rdc(8'h10, 8'h80, "done flag");
        for (int n = 0; n < 7; n++) begin
            rdc(8'h17 + 8'(2 * n), n == 2 ? 8'h00 : {5'h0a, 3'(n)}, "result lo");
            rdc(8'h18 + 8'(2 * n), n == 2 ? 8'h00 : {5'h15, 3'(n)}, "result hi");
        end
        wr(8'h16, 8'h00);
        wr(8'h15, 8'ha0);
        rdc(8'h0c, 8'h00, "done in continuous");
        for (int i = 0; i < 3000 && conv_channel !== 3'h3; i++) @(negedge sys_clk);
        @(posedge sys_clk);
        for (int b = 0; b < 2; b++) begin
            busy[b] <= 1'b1;
            repeat (6) @(posedge sys_clk);
            check("suspended", {15'h0, conv_active}, 16'h0);
            busy[b] <= 1'b0;
            repeat (8) @(posedge sys_clk);
            check("resumed channel", {12'h0, conv_active, conv_channel}, 16'h000b);
        end
        ev[1] <= 1'b1;
        wr(8'h16, 8'h7f);
        for (int i = 0; i < 3000 && !(conv_active && conv_channel == 3'h6); i++) @(negedge sys_clk);
        check("cycle finished", {12'h0, conv_active, conv_channel}, 16'h000e);
        @(posedge sys_clk);
        ev[1] <= 1'b0;
        repeat (700) @(posedge sys_clk);
        check("stopped", {15'h0, conv_active}, 16'h0);
        rdc(8'h15, 8'ha0, "continuous enable kept");
        wr(8'h16, 8'h00);
        repeat (6) @(posedge sys_clk);
        check("restart", {15'h0, conv_active}, 16'h1);
        wr(8'h15, 8'h30);
        repeat (3) @(posedge sys_clk);
        check("stop now", {15'h0, conv_active}, 16'h0);
        rdc(8'h17, 8'h50, "result kept");
        wr(8'h16, 8'h7f);
        f0 = falls;
        wr(8'h15, 8'hf0);
        repeat (4) @(posedge sys_clk);
        rdc(8'h15, 8'h70, "all off oneshot");
        wr(8'h16, 8'h00);
        vbat_valid <= 1'b0;
        vbus_valid <= 1'b0;
        repeat (4) @(posedge sys_clk);
        wr(8'h15, 8'hf0);
        repeat (4) @(posedge sys_clk);
        rdc(8'h15, 8'h70, "no supply");
        check("no pulse", 16'(falls - f0), 16'h0);
        check("idle", {15'h0, conv_active}, 16'h0);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
